// ==== verilog/sfm_pkg.sv ====
/*
 Package for the servo I/O function mapper: register map, function codes,
 factory defaults and field widths.
 Assumes word addressing on the Avalon-MM register bus.
*/
package sfm_pkg;
   localparam int CFG_W = 12;
   localparam int CODE_W = 7;
   localparam int ADDR_W = 5;
   localparam int N_DI = 6;
   localparam int N_DO = 3;
   localparam int N_PRE = 3;
   localparam int FN_MAX = 26;
   localparam int ST_MAX = 10;
   // Decimal digits below the hundreds place hold the function code
   localparam logic [CFG_W-1:0] CODE_MOD = 12'h064;

   // Word addresses
   localparam logic [ADDR_W-1:0] A_DI_CFG0 = 5'h00;
   localparam logic [ADDR_W-1:0] A_DO_CFG0 = 5'h06;
   localparam logic [ADDR_W-1:0] A_TRQ_PRE0 = 5'h09;
   localparam logic [ADDR_W-1:0] A_SPD_PRE0 = 5'h0c;
   localparam logic [ADDR_W-1:0] A_CTRL = 5'h0f;
   localparam logic [ADDR_W-1:0] A_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] A_FUNC = 5'h11;

   // Control register fields
   localparam int CTRL_TRQ_INT = 0;
   localparam int CTRL_SPD_INT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;

   // Input function codes
   localparam int FN_SERVO_ENABLE = 1;
   localparam int FN_ALARM_CLEAR = 2;
   localparam int FN_GAIN_SWITCH = 3;
   localparam int FN_PULSE_CLEAR = 4;
   localparam int FN_ZERO_CLAMP = 5;
   localparam int FN_CMD_REVERSE = 6;
   localparam int FN_PULSE_INHIBIT = 7;
   localparam int FN_TRQ_LIMIT_EN = 9;
   localparam int FN_SPD_LIMIT_EN = 10;
   localparam int FN_GEAR_NUM0 = 11;
   localparam int FN_SPD_SRC0 = 14;
   localparam int FN_SPD_SRC1 = 15;
   localparam int FN_TRQ_SRC0 = 16;
   localparam int FN_TRQ_SRC1 = 17;
   localparam int FN_POS_SPEED = 18;
   localparam int FN_SPEED_TRQ = 19;
   localparam int FN_TRQ_POS = 20;
   localparam int FN_EMERGENCY = 21;
   localparam int FN_REV_TRAVEL = 22;
   localparam int FN_FWD_TRAVEL = 23;
   localparam int FN_REV_TORQUE = 25;
   localparam int FN_FWD_TORQUE = 26;
   localparam logic [FN_MAX:0] FN_DEFINED = 27'h6ffcefe;
   localparam logic [FN_MAX:0] FN_CONTACT_B = 27'h0e00000;
   localparam logic [FN_MAX:0] FN_SINGLE_MODE = 27'h003c000;
   localparam logic [FN_MAX:0] FN_DUAL_MODE = 27'h01c0000;

   // Output status codes
   localparam int ST_SERVO_READY = 1;

   // Factory defaults, written as polarity digit plus code
   localparam logic [CFG_W-1:0] DI_RST [N_DI] = '{12'h065, 12'h066, 12'h068,
                                                   12'h07a, 12'h07b, 12'h079};
   localparam logic [CFG_W-1:0] DO_RST [N_DO] = '{12'h065, 12'h067, 12'h06b};
endpackage

// ==== verilog/sfm_pin_sync.sv ====
/*
 Two-stage synchroniser for the discrete input pins.
 Assumes pins are asynchronous to clk; only the second stage is used.
*/
`timescale 1ns/1ps
module sfm_pin_sync
   import sfm_pkg::*;
#(
   parameter int W = 6
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] pin_sync
);
   if (W < 1)
      $error("W must be at least 1");
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb
   begin
      meta_d = pin;
      sync_d = meta_q;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign pin_sync = sync_q;
endmodule

// ==== verilog/sfm_cmd_select.sv ====
/*
 Command source selector: analog input, zero, or one of three presets.
 Assumes select bits and presets come from logic on the same clock.
*/
`timescale 1ns/1ps
module sfm_cmd_select
   import sfm_pkg::*;
#(
   parameter int W = 16
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic sel0,
   input wire logic sel1,
   input wire logic internal_mode,
   input wire logic [W-1:0] analog_in,
   input wire logic [W-1:0] preset0,
   input wire logic [W-1:0] preset1,
   input wire logic [W-1:0] preset2,
   output logic [W-1:0] cmd
);
   if (W < 1)
      $error("W must be at least 1");
   logic [W-1:0] cmd_q;
   logic [W-1:0] cmd_d;

   always_comb
   begin
      case ({sel1, sel0})
         2'h0: cmd_d = internal_mode ? '0 : analog_in;
         2'h1: cmd_d = preset0;
         2'h2: cmd_d = preset1;
         2'h3: cmd_d = preset2;
         default: cmd_d = '0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         cmd_q <= '0;
      else
         cmd_q <= cmd_d;
   end

   assign cmd = cmd_q;
endmodule

// ==== verilog/sfm_io_mapper.sv ====
/*
 Servo discrete I/O function mapper: six input pins and three output pins
 bound to drive functions by software-written codes, plus speed and
 torque command source selection. Registers over Avalon-MM.
 Assumes drive status inputs and analog samples are on clk.
*/
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module sfm_io_mapper
   import sfm_pkg::*;
#(
   parameter int CMD_W = 16
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [N_DI-1:0] di_pin,
   output logic [N_DO-1:0] do_pin,
   input wire logic stat_servo_ready,
   input wire logic stat_servo_on,
   input wire logic stat_at_zero_speed,
   input wire logic stat_speed_reached,
   input wire logic stat_position_done,
   input wire logic stat_at_torque_limit,
   input wire logic stat_servo_fault,
   input wire logic stat_brake_control,
   input wire logic stat_overload_warning,
   input wire logic stat_servo_warning,
   input wire logic [CMD_W-1:0] analog_speed,
   input wire logic [CMD_W-1:0] analog_torque,
   output logic [CMD_W-1:0] speed_cmd,
   output logic [CMD_W-1:0] torque_cmd,
   output logic servo_enable,
   output logic alarm_clear,
   output logic gain_switch,
   output logic pulse_count_clear,
   output logic zero_speed_clamp,
   output logic command_reverse,
   output logic pulse_inhibit,
   output logic torque_limit_enable,
   output logic speed_limit_enable,
   output logic gear_numerator_sel0,
   output logic pos_speed_sel,
   output logic speed_torque_sel,
   output logic torque_pos_sel,
   output logic emergency_stop,
   output logic reverse_travel_limit,
   output logic forward_travel_limit,
   output logic reverse_torque_limit,
   output logic forward_torque_limit,
   output logic dual_mode_cfg,
   output logic emergency_fault
);
   if (CMD_W < 2 || CMD_W > 32)
      $error("CMD_W must lie in 2..32");

   // Modulo keeps a polarity hundreds digit from aliasing into the code
   function automatic logic [CODE_W-1:0] code_of(input logic [CFG_W-1:0] v);
      logic [CFG_W-1:0] r;
      r = v % CODE_MOD;
      code_of = r[CODE_W-1:0];
   endfunction

   logic [N_DI-1:0] di_sync;
   logic [CFG_W-1:0] di_cfg_q [N_DI];
   logic [CFG_W-1:0] di_cfg_d [N_DI];
   logic [CFG_W-1:0] do_cfg_q [N_DO];
   logic [CFG_W-1:0] do_cfg_d [N_DO];
   logic [CMD_W-1:0] trq_pre_q [N_PRE];
   logic [CMD_W-1:0] trq_pre_d [N_PRE];
   logic [CMD_W-1:0] spd_pre_q [N_PRE];
   logic [CMD_W-1:0] spd_pre_d [N_PRE];
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [FN_MAX:0] func_q;
   logic [FN_MAX:0] func_d;
   logic [N_DO-1:0] do_q;
   logic [N_DO-1:0] do_d;
   logic fault_q;
   logic fault_d;
   logic dual_q;
   logic dual_d;
   logic [ST_MAX:0] status;
   logic req;
   logic wr_en;
   logic [CODE_W-1:0] c;
   logic live_q;

   sfm_pin_sync #(.W(N_DI)) u_sync
   (
      .clk(clk),
      .rstn(rstn),
      .pin(di_pin),
      .pin_sync(di_sync)
   );

   // One wait cycle per access; the write lands on the releasing edge
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_en = avs_write & ack_q;

   always_comb
   begin
      ack_d = req & ~ack_q;
      ctrl_d = ctrl_q;
      for (int i = 0; i < N_DI; i++)
      begin
         di_cfg_d[i] = di_cfg_q[i];
         if (wr_en && avs_address == A_DI_CFG0 + ADDR_W'(i))
            di_cfg_d[i] = avs_writedata[CFG_W-1:0];
      end
      for (int j = 0; j < N_DO; j++)
      begin
         do_cfg_d[j] = do_cfg_q[j];
         if (wr_en && avs_address == A_DO_CFG0 + ADDR_W'(j))
            do_cfg_d[j] = avs_writedata[CFG_W-1:0];
      end
      for (int k = 0; k < N_PRE; k++)
      begin
         trq_pre_d[k] = trq_pre_q[k];
         spd_pre_d[k] = spd_pre_q[k];
         if (wr_en && avs_address == A_TRQ_PRE0 + ADDR_W'(k))
            trq_pre_d[k] = avs_writedata[CMD_W-1:0];
         if (wr_en && avs_address == A_SPD_PRE0 + ADDR_W'(k))
            spd_pre_d[k] = avs_writedata[CMD_W-1:0];
      end
      if (wr_en && avs_address == A_CTRL)
         ctrl_d = avs_writedata[1:0];
      // Unmapped addresses read zero
      rdata_d = rdata_q;
      if (avs_read && !ack_q)
      begin
         rdata_d = '0;
         for (int i = 0; i < N_DI; i++)
            if (avs_address == A_DI_CFG0 + ADDR_W'(i))
               rdata_d[CFG_W-1:0] = di_cfg_q[i];
         for (int j = 0; j < N_DO; j++)
            if (avs_address == A_DO_CFG0 + ADDR_W'(j))
               rdata_d[CFG_W-1:0] = do_cfg_q[j];
         for (int k = 0; k < N_PRE; k++)
         begin
            if (avs_address == A_TRQ_PRE0 + ADDR_W'(k))
               rdata_d[CMD_W-1:0] = trq_pre_q[k];
            if (avs_address == A_SPD_PRE0 + ADDR_W'(k))
               rdata_d[CMD_W-1:0] = spd_pre_q[k];
         end
         if (avs_address == A_CTRL)
            rdata_d[1:0] = ctrl_q;
         if (avs_address == A_STATUS)
            rdata_d[11:0] = {dual_q, fault_q, do_q, di_sync, 1'b0};
         if (avs_address == A_FUNC)
            rdata_d[FN_MAX:0] = func_q;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         ctrl_q <= CTRL_RST;
         for (int i = 0; i < N_DI; i++)
            di_cfg_q[i] <= DI_RST[i];
         for (int j = 0; j < N_DO; j++)
            do_cfg_q[j] <= DO_RST[j];
         for (int k = 0; k < N_PRE; k++)
         begin
            trq_pre_q[k] <= '0;
            spd_pre_q[k] <= '0;
         end
      end
      else
      begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         di_cfg_q <= di_cfg_d;
         do_cfg_q <= do_cfg_d;
         trq_pre_q <= trq_pre_d;
         spd_pre_q <= spd_pre_d;
      end
   end

   assign avs_readdata = rdata_q;

   // Function decode; several pins on one code are ORed
   always_comb
   begin
      func_d = '0;
      dual_d = 1'b0;
      status = {stat_servo_warning, stat_overload_warning, stat_brake_control,
                stat_servo_fault, stat_at_torque_limit, stat_position_done,
                stat_speed_reached, stat_at_zero_speed, stat_servo_on,
                stat_servo_ready, 1'b0};
      for (int i = 0; i < N_DI; i++)
         for (int f = 1; f <= FN_MAX; f++)
            if (code_of(di_cfg_q[i]) == CODE_W'(f))
            begin
               // Contact-b functions are asserted by an open input
               func_d[f] = func_d[f] | (FN_CONTACT_B[f] ? ~di_sync[i] : di_sync[i]);
               dual_d = dual_d | FN_DUAL_MODE[f];
            end
      func_d = func_d & FN_DEFINED;
      for (int j = 0; j < N_DO; j++)
      begin
         c = code_of(do_cfg_q[j]);
         do_d[j] = (c != '0 && c <= CODE_W'(ST_MAX)) ? status[c[3:0]] : 1'b0;
      end
      // Set wins over the alarm-clear function
      fault_d = func_q[FN_EMERGENCY] | (fault_q & ~func_q[FN_ALARM_CLEAR]);
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         func_q <= '0;
         do_q <= '0;
         fault_q <= 1'b0;
         dual_q <= 1'b0;
         live_q <= 1'b0;
      end
      else
      begin
         func_q <= func_d;
         do_q <= do_d;
         fault_q <= fault_d;
         dual_q <= dual_d;
         live_q <= 1'b1;
      end
   end

   assign do_pin = do_q;
   assign emergency_fault = fault_q;
   assign dual_mode_cfg = dual_q;
   assign servo_enable = func_q[FN_SERVO_ENABLE];
   assign alarm_clear = func_q[FN_ALARM_CLEAR];
   assign gain_switch = func_q[FN_GAIN_SWITCH];
   assign pulse_count_clear = func_q[FN_PULSE_CLEAR];
   assign zero_speed_clamp = func_q[FN_ZERO_CLAMP];
   assign command_reverse = func_q[FN_CMD_REVERSE];
   assign pulse_inhibit = func_q[FN_PULSE_INHIBIT];
   assign torque_limit_enable = func_q[FN_TRQ_LIMIT_EN];
   assign speed_limit_enable = func_q[FN_SPD_LIMIT_EN];
   assign gear_numerator_sel0 = func_q[FN_GEAR_NUM0];
   assign pos_speed_sel = func_q[FN_POS_SPEED];
   assign speed_torque_sel = func_q[FN_SPEED_TRQ];
   assign torque_pos_sel = func_q[FN_TRQ_POS];
   assign emergency_stop = func_q[FN_EMERGENCY];
   assign reverse_travel_limit = func_q[FN_REV_TRAVEL];
   assign forward_travel_limit = func_q[FN_FWD_TRAVEL];
   assign reverse_torque_limit = func_q[FN_REV_TORQUE];
   assign forward_torque_limit = func_q[FN_FWD_TORQUE];

   sfm_cmd_select #(.W(CMD_W)) u_spd
   (
      .clk(clk),
      .rstn(rstn),
      .sel0(func_q[FN_SPD_SRC0]),
      .sel1(func_q[FN_SPD_SRC1]),
      .internal_mode(ctrl_q[CTRL_SPD_INT]),
      .analog_in(analog_speed),
      .preset0(spd_pre_q[0]),
      .preset1(spd_pre_q[1]),
      .preset2(spd_pre_q[2]),
      .cmd(speed_cmd)
   );

   sfm_cmd_select #(.W(CMD_W)) u_trq
   (
      .clk(clk),
      .rstn(rstn),
      .sel0(func_q[FN_TRQ_SRC0]),
      .sel1(func_q[FN_TRQ_SRC1]),
      .internal_mode(ctrl_q[CTRL_TRQ_INT]),
      .analog_in(analog_torque),
      .preset0(trq_pre_q[0]),
      .preset1(trq_pre_q[1]),
      .preset2(trq_pre_q[2]),
      .cmd(torque_cmd)
   );

   default clocking @(posedge clk); endclocking
   // Release edge still resets the flops, so checks start one edge later
   default disable iff (!rstn || !live_q);

   trq_zero_a: assert property (!func_q[FN_TRQ_SRC0] && !func_q[FN_TRQ_SRC1] && ctrl_q[CTRL_TRQ_INT] |=> torque_cmd == '0) else $error("torque not zero");
   trq_preset_a: assert property (func_q[FN_TRQ_SRC0] && func_q[FN_TRQ_SRC1] |=> torque_cmd == $past(trq_pre_q[2])) else $error("torque preset wrong");
   spd_analog_a: assert property (!func_q[FN_SPD_SRC0] && !func_q[FN_SPD_SRC1] && !ctrl_q[CTRL_SPD_INT] |=> speed_cmd == $past(analog_speed)) else $error("speed not analog");
   di_route_a: assert property (code_of(di_cfg_q[0]) == CODE_W'(FN_SERVO_ENABLE) && di_sync[0] |=> servo_enable) else $error("servo enable missed");
   contact_b_a: assert property (code_of(di_cfg_q[5]) == CODE_W'(FN_EMERGENCY) && !di_sync[5] |=> emergency_stop ##1 emergency_fault) else $error("contact b stop missed");
   di_off_a: assert property (code_of(di_cfg_q[0]) == '0 && code_of(di_cfg_q[1]) == '0 && code_of(di_cfg_q[2]) == '0 && code_of(di_cfg_q[3]) == '0 && code_of(di_cfg_q[4]) == '0 && code_of(di_cfg_q[5]) == '0 |=> func_q == '0) else $error("disabled input drove function");
   do_off_a: assert property (code_of(do_cfg_q[0]) == '0 |=> !do_pin[0]) else $error("disabled output high");
   do_route_a: assert property (code_of(do_cfg_q[0]) == CODE_W'(ST_SERVO_READY) |=> do_pin[0] == $past(stat_servo_ready)) else $error("ready not routed");
   fault_hold_a: assert property (emergency_fault && !alarm_clear |=> emergency_fault) else $error("fault dropped");
   bus_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");

   bus_write_c: cover property (avs_write && !avs_waitrequest);
   fault_c: cover property ($rose(emergency_fault));
   trq_pre_c: cover property (func_q[FN_TRQ_SRC0] && func_q[FN_TRQ_SRC1]);
   dual_c: cover property (dual_mode_cfg && pos_speed_sel);
endmodule

// ==== verification/sfm_switch_model.sv ====
/*
 Far-side model: the controller or switches on the six input pins.
 Assumes the bench names the wanted levels; pins follow one edge later.
*/
`timescale 1ns/1ps
module sfm_switch_model
   import sfm_pkg::*;
(
   input wire logic clk,
   input wire logic [N_DI-1:0] want,
   output logic [N_DI-1:0] di_pin
);
   // Contacts change just after an edge; no bounce, so waits stay short
   always_ff @(posedge clk)
   begin
      di_pin <= want;
   end
endmodule

// ==== verification/tb_top.sv ====
/*
 Bench for the I/O function mapper: bus tasks and directed sequences.
 Assumes the package is compiled first and pins come from the switch model.
*/
`timescale 1ns/1ps
module tb_top
   import sfm_pkg::*;
;
   localparam int DI_DEF [6] = '{1, 2, 4, 22, 23, 21};
   localparam int DO_DEF [3] = '{1, 3, 7};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest;
   logic [N_DI-1:0] want = 6'h00;
   wire logic [N_DI-1:0] di_pin;
   wire logic [N_DO-1:0] do_pin;
   logic [9:0] stat = 10'h000;
   logic [15:0] ana_spd = 16'h5def;
   logic [15:0] ana_trq = 16'h7abc;
   wire logic [15:0] speed_cmd, torque_cmd;
   wire logic servo_enable, alarm_clear, gain_switch, pulse_count_clear, zero_speed_clamp;
   wire logic command_reverse, pulse_inhibit, torque_limit_enable, speed_limit_enable;
   wire logic gear_numerator_sel0, pos_speed_sel, speed_torque_sel, torque_pos_sel;
   wire logic emergency_stop, reverse_travel_limit, forward_travel_limit;
   wire logic reverse_torque_limit, forward_torque_limit, dual_mode_cfg, emergency_fault;
   wire logic [31:0] fn_p;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;

   // Function ports laid out by code; select codes 14-17 show only in the commands
   assign fn_p = {5'h00, forward_torque_limit, reverse_torque_limit, 1'b0,
      forward_travel_limit, reverse_travel_limit, emergency_stop, torque_pos_sel,
      speed_torque_sel, pos_speed_sel, 6'h00, gear_numerator_sel0, speed_limit_enable,
      torque_limit_enable, 1'b0, pulse_inhibit, command_reverse, zero_speed_clamp,
      pulse_count_clear, gain_switch, alarm_clear, servo_enable, 1'b0};

   always #2 clk = ~clk;

   sfm_switch_model sw (.clk(clk), .want(want), .di_pin(di_pin));

   sfm_io_mapper dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .di_pin(di_pin),
      .do_pin(do_pin), .stat_servo_ready(stat[0]), .stat_servo_on(stat[1]),
      .stat_at_zero_speed(stat[2]), .stat_speed_reached(stat[3]),
      .stat_position_done(stat[4]), .stat_at_torque_limit(stat[5]),
      .stat_servo_fault(stat[6]), .stat_brake_control(stat[7]),
      .stat_overload_warning(stat[8]), .stat_servo_warning(stat[9]),
      .analog_speed(ana_spd), .analog_torque(ana_trq), .speed_cmd(speed_cmd),
      .torque_cmd(torque_cmd), .servo_enable(servo_enable), .alarm_clear(alarm_clear),
      .gain_switch(gain_switch), .pulse_count_clear(pulse_count_clear),
      .zero_speed_clamp(zero_speed_clamp), .command_reverse(command_reverse),
      .pulse_inhibit(pulse_inhibit), .torque_limit_enable(torque_limit_enable),
      .speed_limit_enable(speed_limit_enable), .gear_numerator_sel0(gear_numerator_sel0),
      .pos_speed_sel(pos_speed_sel), .speed_torque_sel(speed_torque_sel),
      .torque_pos_sel(torque_pos_sel), .emergency_stop(emergency_stop),
      .reverse_travel_limit(reverse_travel_limit),
      .forward_travel_limit(forward_travel_limit),
      .reverse_torque_limit(reverse_torque_limit),
      .forward_torque_limit(forward_torque_limit), .dual_mode_cfg(dual_mode_cfg),
      .emergency_fault(emergency_fault));

   task automatic close_out;
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input int a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      avs_address <= ADDR_W'(a);
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0);
      // One wait cycle per access, so the answer comes at the second edge
      chk(32'(n), 32'h2);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input int a, input logic [31:0] d);
      logic [31:0] t;
      bus(1'b1, a, d, t);
   endtask

   task automatic rdc(input int a, input logic [31:0] exp);
      logic [31:0] t;
      bus(1'b0, a, 32'h0, t);
      chk(t, exp);
   endtask

   function automatic logic [31:0] fexp(input int c, input logic p);
      logic def;
      def = (c >= 1 && c <= 7) || (c >= 9 && c <= 11) || (c >= 14 && c <= 23)
            || c == 25 || c == 26;
      if (!def)
         return 32'h0;
      // Break contacts assert with the pin off
      return ((c >= 21 && c <= 23) ? !p : p) ? (32'h1 << c) : 32'h0;
   endfunction

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         close_out;
      end
   end

   initial
   begin
      int e;
      idle(4);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rdc(A_DI_CFG0 + i, 32'(100 + DI_DEF[i]));
      for (int i = 0; i < 3; i++)
         rdc(A_DO_CFG0 + i, 32'(100 + DO_DEF[i]));
      wr(5'h1f, 32'h5);
      rdc(5'h1f, 32'h0);
      idle(4);
      chk(fn_p, 32'h00e00000);
      chk({31'h0, emergency_fault}, 32'h1);
      rdc(A_STATUS, 32'h400);
      want <= 6'h23;
      idle(6);
      chk(fn_p, 32'h00c00006);
      chk({31'h0, emergency_fault}, 32'h0);
      rdc(A_STATUS, 32'h46);
      for (int i = 1; i < 6; i++)
         wr(A_DI_CFG0 + i, 32'h0);
      for (int c = 0; c < 28; c++)
      begin
         wr(A_DI_CFG0, 32'(100 + c));
         for (int p = 0; p < 2; p++)
         begin
            want <= {5'h00, p[0]};
            idle(6);
            rdc(A_FUNC, fexp(c, p[0]));
            chk(fn_p & 32'hfffc3fff, fexp(c, p[0]) & 32'hfffc3fff);
            chk({31'h0, dual_mode_cfg}, 32'(c >= 18 && c <= 20));
         end
      end
      for (int c = 0; c < 12; c++)
      begin
         wr(A_DO_CFG0, 32'(100 + c));
         for (int s = 0; s < 2; s++)
         begin
            stat <= (c >= 1 && c <= 10) ? 10'(s ? 1 << (c - 1) : ~(1 << (c - 1)))
                    : (s ? 10'h3ff : 10'h000);
            idle(3);
            e = s == 1 && c >= 1 && c <= 10;
            chk({31'h0, do_pin[0]}, 32'(e));
            chk({30'h0, do_pin[2:1]}, {30'h0, stat[6], stat[2]});
         end
      end
      wr(A_DI_CFG0, 32'h74);
      wr(A_DI_CFG0 + 1, 32'h75);
      wr(A_DI_CFG0 + 2, 32'h72);
      wr(A_DI_CFG0 + 3, 32'h73);
      for (int k = 0; k < 3; k++)
      begin
         wr(A_TRQ_PRE0 + k, 32'h1101 + k);
         wr(A_SPD_PRE0 + k, 32'h2201 + k);
      end
      for (int m = 0; m < 4; m++)
         for (int s = 0; s < 4; s++)
         begin
            wr(A_CTRL, 32'(m));
            want <= {2'h0, s[1:0], s[1:0]};
            ana_trq <= 16'h7a00 + 16'(4 * m + s);
            ana_spd <= 16'h5d00 + 16'(4 * m + s);
            idle(6);
            e = s == 0 ? (m[0] ? 0 : 32'h7a00 + 4 * m) : 32'h1100 + s;
            chk({16'h0, torque_cmd}, 32'(e));
            e = s == 0 ? (m[1] ? 0 : 32'h5d00 + 4 * m) : 32'h2200 + s;
            chk({16'h0, speed_cmd}, 32'(e));
         end
      close_out;
   end
endmodule
